/* verilog/timer_prescaler_clock_select.sv */
// Prescaler, clock gating and underflow routing for eight 8-bit down-counting timers.
`timescale 1ns/1ps

// What this block does
// - Timer 1/7 underflow clocks serial channel 0/1.
// - Serial channel divides underflow rate by 32.
// - Serial bit rate ignores compare value.
// - Timer 5 underflow can clock LCD frames.
// - LCD divides by 128, or 256 at 1/8.
// - LCD frame rate ignores compare value.
// - Per-timer clock gate bit, resets off.
// - High-speed ratios 4096 down to 1.
// - Low-speed ratios 128 down to 1.
// - Per-timer source bit: 1 low-speed, 0 high-speed.
// - Underflow pulses and reloads the counter.
// - Timers 4-7 have own source bits.
module timer_prescaler_clock_select
	import timer_clock_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEnable,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic highSpeedTick,
	input wire logic lowSpeedOscPin,
	input wire logic [63:0] reloadValues,
	input wire logic lcdUseTimer5,
	input wire logic lcdDutyEighth,
	output logic [7:0] timerUnderflow,
	output logic serial0BitTick,
	output logic serial1BitTick,
	output logic lcdFrameTick
);
	logic [7:0] setupReg [4];
	logic [7:0] source03Reg;
	logic [7:0] source47Reg;
	logic [2:0] lsSync;
	logic lsLevelReg;
	logic lsEdge;
	logic [HS_DIV_W-1:0] hsDivReg;
	logic [LS_DIV_W-1:0] lsDivReg;
	logic [7:0] countReg [TIMER_COUNT];
	logic [7:0] prescaledTick;
	logic [7:0] gateBits;
	logic [7:0] sourceBits;
	logic [4:0] serial0CntReg;
	logic [4:0] serial1CntReg;
	logic [7:0] lcdCntReg;
	logic [7:0] lcdLast;
	logic [31:0] wordIdx;
	logic setupHit;
	logic mapped;
	logic [1:0] setupSel;
	logic [7:0] readValue;
	logic accessDone;

	// Word index of the access and the decode of the six registers.
	assign wordIdx = paddr >> ADDR_SHIFT;
	assign setupHit = (wordIdx == TIMER01_CLOCK_SETUP_IDX) || (wordIdx == TIMER23_CLOCK_SETUP_IDX) ||
		(wordIdx == TIMER45_CLOCK_SETUP_IDX) || (wordIdx == TIMER67_CLOCK_SETUP_IDX);
	assign mapped = setupHit || (wordIdx == TIMER0TO3_SOURCE_SELECT_IDX) ||
		(wordIdx == TIMER4TO7_SOURCE_SELECT_IDX);
	assign accessDone = psel && penable && pready;

	// Map a setup index onto its slot in the setup array.
	always_comb begin
		case (wordIdx)
			TIMER01_CLOCK_SETUP_IDX: setupSel = 2'h0;
			TIMER23_CLOCK_SETUP_IDX: setupSel = 2'h1;
			TIMER45_CLOCK_SETUP_IDX: setupSel = 2'h2;
			default: setupSel = 2'h3;
		endcase
	end

	// Read mux; source select bits outside SOURCE03_MASK and SOURCE47_MASK read as zero.
	always_comb begin
		if (setupHit) begin
			readValue = setupReg[setupSel];
		end else if (wordIdx == TIMER0TO3_SOURCE_SELECT_IDX) begin
			readValue = source03Reg & SOURCE03_MASK;
		end else if (wordIdx == TIMER4TO7_SOURCE_SELECT_IDX) begin
			readValue = source47Reg & SOURCE47_MASK;
		end else begin
			readValue = 8'h00;
		end
	end

	// APB answer: one wait state, so pready rises in the second access cycle.
	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (clkEnable) begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				prdata <= pwrite ? 32'h00000000 : {24'h000000, readValue};
				pslverr <= !mapped;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// Register writes take effect at the completing edge only.
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				setupReg[i] <= SETUP_RESET;
			end
			source03Reg <= SOURCE_RESET;
			source47Reg <= SOURCE_RESET;
		end else if (clkEnable && accessDone && pwrite) begin
			if (setupHit) begin
				setupReg[setupSel] <= pwdata[7:0];
			end else if (wordIdx == TIMER0TO3_SOURCE_SELECT_IDX) begin
				source03Reg <= pwdata[7:0] & SOURCE03_MASK;
			end else if (wordIdx == TIMER4TO7_SOURCE_SELECT_IDX) begin
				source47Reg <= pwdata[7:0] & SOURCE47_MASK;
			end
		end
	end

	// The low-speed oscillator is a pin: three stages, a change counts when stages two
	// and three agree, so a metastable first stage never reaches the edge detector.
	always_ff @(posedge clk) begin
		if (reset) begin
			lsSync <= 3'h0;
			lsLevelReg <= 1'b0;
		end else if (clkEnable) begin
			lsSync <= {lsSync[1:0], lowSpeedOscPin};
			if (lsSync[1] == lsSync[2]) begin
				lsLevelReg <= lsSync[2];
			end
		end
	end
	assign lsEdge = (lsSync[1] == lsSync[2]) && lsSync[2] && !lsLevelReg;

	// Shared free-running dividers; every timer taps its own power of two from them,
	// which costs one counter per source instead of one per timer.
	always_ff @(posedge clk) begin
		if (reset) begin
			hsDivReg <= '0;
			lsDivReg <= '0;
		end else if (clkEnable) begin
			if (highSpeedTick) begin
				hsDivReg <= hsDivReg + 1'b1;
			end
			if (lsEdge) begin
				lsDivReg <= lsDivReg + 1'b1;
			end
		end
	end

	// Per-timer source, ratio and gate, then the down counter with reload.
	for (genvar t = 0; t < TIMER_COUNT; t++) begin : gTimer
		logic [3:0] nibble;
		logic [2:0] ratio;
		logic [HS_DIV_W-1:0] hsMask;
		logic [LS_DIV_W-1:0] lsMask;
		logic [7:0] reload;
		assign nibble = setupReg[t/2][(t%2)*NIBBLE_W +: NIBBLE_W];
		assign ratio = nibble[RATIO_LSB +: RATIO_W];
		assign gateBits[t] = nibble[GATE_BIT];
		assign sourceBits[t] = (t < 4) ? source03Reg[t%4] : source47Reg[t%4];
		assign hsMask = HS_DIV_W'((13'h0001 << HS_SHIFT[7 - ratio]) - 13'h0001);
		assign lsMask = LS_DIV_W'((8'h01 << LS_SHIFT[7 - ratio]) - 8'h01);
		// Source select picks the prescaler tap; 1 is the low-speed oscillator.
		assign prescaledTick[t] = sourceBits[t] ?
			(lsEdge && ((lsDivReg & lsMask) == lsMask)) :
			(highSpeedTick && ((hsDivReg & hsMask) == hsMask));
		assign reload = reloadValues[t*8 +: 8];

		// The gate bit blocks the prescaled clock; compare value plays no part here.
		always_ff @(posedge clk) begin
			if (reset) begin
				countReg[t] <= 8'h00;
				timerUnderflow[t] <= 1'b0;
			end else if (clkEnable) begin
				timerUnderflow[t] <= 1'b0;
				if (prescaledTick[t] && gateBits[t]) begin
					if (countReg[t] == 8'h00) begin
						countReg[t] <= reload;
						timerUnderflow[t] <= 1'b1;
					end else begin
						countReg[t] <= countReg[t] - 8'h01;
					end
				end
			end
		end

		// With the low-speed source and no synced edge the timer cannot step.
		// This catches a source bit that reaches the wrong prescaler tap.
		a_source_low_speed: assert property (@(posedge clk) disable iff (reset)
			gateBits[t] && sourceBits[t] && !lsEdge && clkEnable |=> !timerUnderflow[t])
			else $error("timer stepped without a low-speed edge");
	end

	// Serial channels divide their timer's underflow by 32; only underflow matters.
	always_ff @(posedge clk) begin
		if (reset) begin
			serial0CntReg <= 5'h00;
			serial1CntReg <= 5'h00;
			serial0BitTick <= 1'b0;
			serial1BitTick <= 1'b0;
		end else if (clkEnable) begin
			serial0BitTick <= timerUnderflow[SERIAL0_TIMER] && (serial0CntReg == SERIAL_LAST);
			serial1BitTick <= timerUnderflow[SERIAL1_TIMER] && (serial1CntReg == SERIAL_LAST);
			if (timerUnderflow[SERIAL0_TIMER]) begin
				serial0CntReg <= serial0CntReg + 5'h01;
			end
			if (timerUnderflow[SERIAL1_TIMER]) begin
				serial1CntReg <= serial1CntReg + 5'h01;
			end
		end
	end

	// Frame divider: 256 at 1/8 duty, 128 otherwise; stalls while not routed.
	assign lcdLast = lcdDutyEighth ? LCD_LAST_LONG : LCD_LAST_SHORT;
	always_ff @(posedge clk) begin
		if (reset) begin
			lcdCntReg <= 8'h00;
			lcdFrameTick <= 1'b0;
		end else if (clkEnable) begin
			lcdFrameTick <= 1'b0;
			if (lcdUseTimer5 && timerUnderflow[LCD_TIMER]) begin
				if (lcdCntReg >= lcdLast) begin
					lcdCntReg <= 8'h00;
					lcdFrameTick <= 1'b1;
				end else begin
					lcdCntReg <= lcdCntReg + 8'h01;
				end
			end
		end
	end

	// Helper: underflows of timer 1 since the last serial 0 bit tick.
	logic [5:0] helpUfl1Reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			helpUfl1Reg <= 6'h00;
		end else if (clkEnable) begin
			if (serial0BitTick) begin
				helpUfl1Reg <= {5'h00, timerUnderflow[SERIAL0_TIMER]};
			end else if (timerUnderflow[SERIAL0_TIMER]) begin
				helpUfl1Reg <= helpUfl1Reg + 6'h01;
			end
		end
	end

	// Helper: underflows of timer 7 since the last serial 1 bit tick.
	logic [5:0] helpUfl7Reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			helpUfl7Reg <= 6'h00;
		end else if (clkEnable) begin
			if (serial1BitTick) begin
				helpUfl7Reg <= {5'h00, timerUnderflow[SERIAL1_TIMER]};
			end else if (timerUnderflow[SERIAL1_TIMER]) begin
				helpUfl7Reg <= helpUfl7Reg + 6'h01;
			end
		end
	end

	// Divider, routing and reload checks; the helpers count underflows themselves and restart on each bit tick.
	a_serial_div_count: assert property (@(posedge clk) disable iff (reset)
		serial0BitTick |-> $past(helpUfl1Reg) == 6'(SERIAL_DIV - 1))
		else $error("serial 0 bit tick not after 32 underflows");
	a_serial_source_timer: assert property (@(posedge clk) disable iff (reset)
		serial1BitTick |-> $past(timerUnderflow[SERIAL1_TIMER]) && $past(clkEnable))
		else $error("serial 1 tick without timer 7 underflow");
	a_underflow_reload: assert property (@(posedge clk) disable iff (reset)
		$rose(timerUnderflow[0]) |-> countReg[0] == $past(reloadValues[7:0]))
		else $error("counter not reloaded on underflow");
	a_gate_blocks_clock: assert property (@(posedge clk) disable iff (reset)
		!gateBits[2] ##1 !gateBits[2] |-> !timerUnderflow[2])
		else $error("underflow while clock gate off");
	a_lcd_route_off: assert property (@(posedge clk) disable iff (reset)
		!lcdUseTimer5 ##1 !lcdUseTimer5 |-> !lcdFrameTick)
		else $error("frame tick while timer 5 not routed");
	a_lcd_frame_wrap: assert property (@(posedge clk) disable iff (reset)
		lcdFrameTick |-> lcdCntReg == 8'h00 && $past(lcdCntReg) == $past(lcdLast))
		else $error("frame tick not at divider wrap");
	a_reserved_reads_zero: assert property (@(posedge clk) disable iff (reset)
		(source03Reg & ~SOURCE03_MASK) == 8'h00 && (source47Reg & ~SOURCE47_MASK) == 8'h00)
		else $error("undefined source select bit set");
	a_apb_one_wait: assert property (@(posedge clk) disable iff (reset)
		psel && penable && !pready && clkEnable |=> pready)
		else $error("apb answer late");
	a_hs_ratio_one: assert property (@(posedge clk) disable iff (reset)
		gateBits[0] && !sourceBits[0] && ratio0Is0() && highSpeedTick && clkEnable
		|=> timerUnderflow[0] || countReg[0] == $past(countReg[0]) - 8'h01)
		else $error("divide by one does not count every tick");
	function automatic logic ratio0Is0();
		return setupReg[0][RATIO_LSB +: RATIO_W] == 3'h0;
	endfunction : ratio0Is0

	// The second serial channel and the frame divider follow only their routed underflows.
	a_serial1_div_count: assert property (@(posedge clk) disable iff (reset)
		serial1BitTick |-> $past(helpUfl7Reg) == 6'(SERIAL_DIV - 1))
		else $error("serial 1 bit tick not after 32 underflows");
	a_frame_source: assert property (@(posedge clk) disable iff (reset)
		lcdFrameTick |-> $past(timerUnderflow[LCD_TIMER]) && $past(lcdUseTimer5))
		else $error("frame tick without routed timer 5 underflow");
	a_lcd_hold_unrouted: assert property (@(posedge clk) disable iff (reset)
		!lcdUseTimer5 |=> $stable(lcdCntReg))
		else $error("frame divider moved while not routed");

	// Enable, reset and bus answer checks.
	a_enable_freeze: assert property (@(posedge clk) disable iff (reset)
		!clkEnable |=> $stable(hsDivReg) && $stable(countReg[0]))
		else $error("state moved while clock enable low");
	a_reset_gates_off: assert property (@(posedge clk) disable iff (reset)
		$past(reset) |-> gateBits == 8'h00 && sourceBits == 8'h00)
		else $error("gate or source bit set after reset");
	a_prdata_upper_zero: assert property (@(posedge clk) disable iff (reset)
		pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read data bits not zero");
	a_error_with_ready: assert property (@(posedge clk) disable iff (reset)
		pslverr |-> pready)
		else $error("bus error without ready");
	a_ready_one_cycle: assert property (@(posedge clk) disable iff (reset)
		pready && clkEnable |=> !pready)
		else $error("ready held longer than one cycle");

	// Main scenarios that the bench is expected to reach.
	c_serial_tick: cover property (@(posedge clk) disable iff (reset) serial0BitTick);
	c_serial1_tick: cover property (@(posedge clk) disable iff (reset) serial1BitTick);
	c_apb_error: cover property (@(posedge clk) disable iff (reset) pslverr);
	c_lcd_long_frame: cover property (@(posedge clk) disable iff (reset)
		lcdFrameTick && lcdDutyEighth);
	c_low_speed_underflow: cover property (@(posedge clk) disable iff (reset)
		timerUnderflow[3] && sourceBits[3]);
endmodule : timer_prescaler_clock_select

/* pkg/timer_clock_pkg.sv */
// Constants for the timer prescaler and clock select block.
package timer_clock_pkg;
	// Register indexes; the byte address is four times the index.
	localparam logic [31:0] TIMER01_CLOCK_SETUP_IDX = 32'h0000FF14;
	localparam logic [31:0] TIMER23_CLOCK_SETUP_IDX = 32'h0000FF15;
	localparam logic [31:0] TIMER0TO3_SOURCE_SELECT_IDX = 32'h0000FF17;
	localparam logic [31:0] TIMER45_CLOCK_SETUP_IDX = 32'h0000FF18;
	localparam logic [31:0] TIMER67_CLOCK_SETUP_IDX = 32'h0000FF19;
	localparam logic [31:0] TIMER4TO7_SOURCE_SELECT_IDX = 32'h0000FF1B;
	localparam int ADDR_SHIFT = 2;
	// Reset values.
	localparam logic [7:0] SETUP_RESET = 8'h00;
	localparam logic [7:0] SOURCE_RESET = 8'h00;
	// Writable bit masks; other bits read as zero.
	localparam logic [7:0] SOURCE03_MASK = 8'h1F;
	localparam logic [7:0] SOURCE47_MASK = 8'h0F;
	// Field layout of a clock setup byte: odd timer high nibble, even timer low.
	localparam int GATE_BIT = 3;
	localparam int RATIO_LSB = 0;
	localparam int RATIO_W = 3;
	localparam int NIBBLE_W = 4;
	localparam int TIMER_COUNT = 8;
	// Prescaler widths and division exponents per ratio code.
	localparam int HS_DIV_W = 12;
	localparam int LS_DIV_W = 7;
	localparam logic [3:0] HS_SHIFT [8] = '{4'hC, 4'hA, 4'h8, 4'h6, 4'h5, 4'h3, 4'h1, 4'h0};
	localparam logic [3:0] LS_SHIFT [8] = '{4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
	// Timers routed to other blocks.
	localparam int SERIAL0_TIMER = 1;
	localparam int SERIAL1_TIMER = 7;
	localparam int LCD_TIMER = 5;
	// Divisors in the serial channels and the frame generator.
	localparam int SERIAL_DIV = 32;
	localparam int LCD_DIV_SHORT = 128;
	localparam int LCD_DIV_LONG = 256;
	localparam logic [4:0] SERIAL_LAST = 5'(SERIAL_DIV - 1);
	localparam logic [7:0] LCD_LAST_SHORT = 8'(LCD_DIV_SHORT - 1);
	localparam logic [7:0] LCD_LAST_LONG = 8'(LCD_DIV_LONG - 1);
endpackage : timer_clock_pkg

/* verif/test_timer_prescaler_clock_select.sv */
// Self-checking bench for the timer prescaler and clock select block.
`timescale 1ns/1ps
module test_timer_prescaler_clock_select
	import timer_clock_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clkEnable = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic highSpeedTick = 1'b1;
	logic lowSpeedOscPin = 1'b0;
	logic [1:0] lsDiv = 2'h0;
	logic [63:0] reloadValues = 64'h0;
	logic lcdUseTimer5 = 1'b0;
	logic lcdDutyEighth = 1'b0;
	wire [31:0] prdata;
	wire pready, pslverr, serial0BitTick, serial1BitTick, lcdFrameTick;
	wire [7:0] timerUnderflow;
	wire [10:0] obs = {lcdFrameTick, serial1BitTick, serial0BitTick, timerUnderflow};
	logic [31:0] regAddr [6];
	logic [31:0] regMask [6] = '{32'hFF, 32'hFF, 32'h1F, 32'hFF, 32'hFF, 32'h0F};
	int setupSlot [4] = '{0, 1, 3, 4};
	int error_cnt = 0;
	int checks = 0;
	int cycles = 0;

	timer_prescaler_clock_select u_dut (.clk(clk), .reset(reset), .clkEnable(clkEnable),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .highSpeedTick(highSpeedTick),
		.lowSpeedOscPin(lowSpeedOscPin), .reloadValues(reloadValues),
		.lcdUseTimer5(lcdUseTimer5), .lcdDutyEighth(lcdDutyEighth),
		.timerUnderflow(timerUnderflow), .serial0BitTick(serial0BitTick),
		.serial1BitTick(serial1BitTick), .lcdFrameTick(lcdFrameTick));

	// Clock at 40 MHz.
	initial begin
		forever #12.5 clk = ~clk;
	end

	// Slow oscillator with a four-cycle period, free running like a real crystal.
	always @(posedge clk) begin
		lsDiv <= lsDiv + 2'h1;
		lowSpeedOscPin <= lsDiv[1];
	end

	// A hang ends the run as a failure.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 95000) begin
			error_cnt++;
			final_report();
		end
	end

	task automatic final_report;
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; the request stands until pready is sampled high at a rising edge.
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Bounded wait for the next pulse on one observed output.
	task automatic wait_pulse(input int idx, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (obs[idx] !== 1'b1 && n < 40000);
	endtask : wait_pulse

	// The first interval may be short because the prescaler phase is not reset.
	task automatic period(input int idx, input int exp);
		int n;
		wait_pulse(idx, n);
		wait_pulse(idx, n);
		wait_pulse(idx, n);
		check(32'(n), 32'(exp));
	endtask : period

	function automatic int exp_period(input bit ls, input int code, input int r);
		int hs [8] = '{1, 2, 8, 32, 64, 256, 1024, 4096};
		return ls ? 4 * (1 << code) * (r + 1) : hs[code] * (r + 1);
	endfunction : exp_period

	// Main sequence.
	initial begin
		logic [31:0] d;
		logic [31:0] w;
		logic e;
		int t, c, r;
		bit ls;
		void'($urandom(32'hC29D));
		regAddr = '{TIMER01_CLOCK_SETUP_IDX << ADDR_SHIFT, TIMER23_CLOCK_SETUP_IDX << ADDR_SHIFT,
			TIMER0TO3_SOURCE_SELECT_IDX << ADDR_SHIFT, TIMER45_CLOCK_SETUP_IDX << ADDR_SHIFT,
			TIMER67_CLOCK_SETUP_IDX << ADDR_SHIFT, TIMER4TO7_SOURCE_SELECT_IDX << ADDR_SHIFT};
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		// Freeze briefly with the enable low before any traffic.
		repeat (2) @(posedge clk);
		clkEnable <= 1'b0;
		repeat (8) @(posedge clk);
		clkEnable <= 1'b1;
		// Reset values, then random write and masked read back.
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, regAddr[i], 32'h0, d, e);
			check(d, 32'h0);
			w = $urandom;
			apb(1'b1, regAddr[i], w, d, e);
			check({31'h0, e}, 32'h0);
			apb(1'b0, regAddr[i], 32'h0, d, e);
			check(d, w & regMask[i]);
		end
		apb(1'b1, 32'h10, 32'hFFFFFFFF, d, e);
		check({31'h0, e}, 32'h1);
		apb(1'b0, 32'h10, 32'h0, d, e);
		check(d, 32'h0);
		// Every ratio code on both sources, on a random timer.
		for (int k = 0; k < 16; k++) begin
			ls = (k >= 8);
			c = k % 8;
			t = $urandom_range(7, 0);
			r = $urandom_range(1, 0);
			@(posedge clk);
			reloadValues[8 * t +: 8] <= 8'(r);
			apb(1'b1, t < 4 ? regAddr[2] : regAddr[5], 32'(ls) << (t % 4), d, e);
			apb(1'b1, regAddr[setupSlot[t / 2]], 32'(4'h8 | c) << (4 * (t % 2)), d, e);
			period(t, exp_period(ls, c, r));
		end
		// Gate off stops a timer that was running; a pulse already launched may still show.
		@(posedge clk);
		reloadValues <= 64'h0;
		apb(1'b1, regAddr[0], 32'h80, d, e);
		wait_pulse(1, c);
		check(32'(c < 40000), 32'h1);
		apb(1'b1, regAddr[0], 32'h0, d, e);
		repeat (2) @(posedge clk);
		c = 0;
		repeat (64) begin
			@(negedge clk);
			c += int'(timerUnderflow[1]);
		end
		check(32'(c), 32'h0);
		// Serial channels and frame divider fed by underflows every cycle.
		apb(1'b1, regAddr[2], 32'h0, d, e);
		apb(1'b1, regAddr[5], 32'h0, d, e);
		apb(1'b1, regAddr[0], 32'h80, d, e);
		apb(1'b1, regAddr[4], 32'h80, d, e);
		apb(1'b1, regAddr[3], 32'h80, d, e);
		period(8, 32);
		period(9, 32);
		c = 0;
		repeat (600) begin
			@(negedge clk);
			c += int'(lcdFrameTick);
		end
		check(32'(c), 32'h0);
		@(posedge clk);
		lcdUseTimer5 <= 1'b1;
		period(10, 128);
		@(posedge clk);
		lcdDutyEighth <= 1'b1;
		period(10, 256);
		final_report();
	end
endmodule : test_timer_prescaler_clock_select
